// file: pkg/ind_ctrl_consts.svh
// offsets, field positions, reset values and timing of the indicator block
// assumes inclusion by bare name from the design file
`ifndef IND_CTRL_CONSTS_SVH
`define IND_CTRL_CONSTS_SVH
// register indices; the byte address is four times the index
`define IND_SRC_IDX 10'h016
`define IND_TIM_IDX 10'h018
`define IND_POL_IDX 10'h019
`define IND_STAT_IDX 10'h01a
// reset values and writable masks
`define IND_SRC_RST 16'h4a44
`define IND_TIM_RST 16'h4205
`define IND_TIM_WMASK 16'h7fff
`define IND_POL_RST 16'h0000
`define IND_POL_WMASK 16'h7000
// field positions
`define SRC2_LSB 8
`define SRC1_LSB 4
`define SRC0_LSB 0
`define STRETCH_LSB 12
`define BLINK_LSB 9
`define SPD2_LSB 6
`define SPD1_LSB 3
`define SPD0_LSB 0
`define POL_LSB 12
// source and speed codes
`define SRC_IRQ_OR_COLB 4'he
`define SRC_OFF 4'hf
`define SPD_TEN 3'h0
`define SPD_HUNDRED 3'h5
// timing
`define CLK_NS 25
`define MS_NS 1000000
`define STRETCH_BASE_MS 21
`endif

// file: pkg/ind_ctrl_pkg.sv
// types shared by the indicator block and its bench
// assumes the constants header sits beside it
package ind_ctrl_pkg;
    // line conditions reported by the transceiver core
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_duplex;
        logic collision;
        logic rx_error;
        logic tx_active;
        logic rx_active;
        logic irq;
    } line_state_type;
    // conditions after stretching, as the source selector sees them
    typedef struct packed {
        logic coll;
        logic err;
        logic dup;
        logic link;
        logic tx;
        logic rx;
        logic irq;
        logic blink;
    } cond_type;
endpackage

// file: src/ind_ctrl.sv
// indicator drive logic: source select, stretch, blink, speed, polarity
// assumes line conditions synchronous to pclk and an apb master
//
// Summary of operation
// RQ1 - output two picks its source from bits 11:8, interrupt on code 1110
// RQ2 - output one uses bits 7:4, same codes, no interrupt source
// RQ3 - output zero uses bits 3:0; 1110 blinks collision; no act, link/rx
// RQ4 - source code 1111 holds the output inactive always
// RQ5 - bits 14:12 stretch short events; 000 off, 001..111 doubling from 21ms
// RQ6 - bits 11:9 pick blink period 42..670 ms; codes above 100 reserved
// RQ7 - per output speed field: 000 means 10 mbit link, 101 100 mbit
// RQ8 - outputs are active low unless their inversion bit is set
// RQ9 - blinking sources toggle at blink period while present, else inactive
`include "ind_ctrl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ind_ctrl
    import ind_ctrl_pkg::*;
#(
    parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // line conditions
    input wire line_state_type line_st,
    // lamp pins
    output logic [2:0] ind_pin
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [15:0] src_r;
    logic [15:0] tim_r;
    logic [15:0] pol_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [2:0] pin_r;
    logic [2:0] act_r;
    logic [2:0] act_nxt;
    logic [15:0] ms_cnt_r;
    logic ms_tick_r;
    logic [8:0] blink_cnt_r;
    logic blink_r;
    logic [11:0] str_cnt_r [4];
    logic [3:0] ev;
    logic [3:0] ev_str;
    logic [2:0] stretch_code;
    logic [2:0] blink_code;
    logic [2:0] inv;
    logic [9:0] idx;
    logic wr_en;
    cond_type cond;

    assign stretch_code = tim_r[`STRETCH_LSB +: 3];
    assign blink_code = tim_r[`BLINK_LSB +: 3];
    assign inv = pol_r[`POL_LSB +: 3];
    assign idx = paddr[11:2];
    assign wr_en = psel && penable && pready_r && pwrite;

    ////////////////////////////////////////////////////////////////////////
    // functions

    // stretch reload in ms ticks for a code; one tick more than the shortest
    // hold, since the first tick after the event may come at once and would
    // otherwise cut the hold below the lower bound of its range
    function automatic logic [11:0] stretch_ms(input logic [2:0] code);
        logic [11:0] base;
        base = 12'(`STRETCH_BASE_MS);
        if (code == 3'h0) begin
            stretch_ms = 12'h000;
        end else begin
            stretch_ms = 12'(base << (code - 3'h1)) + 12'h001;
        end
    endfunction

    // half the blink period in ms; reserved codes fall back to 42 ms, as code 001
    function automatic logic [8:0] blink_half_ms(input logic [2:0] code);
        case (code)
            3'h0: blink_half_ms = 9'h015;
            3'h1: blink_half_ms = 9'h02a;
            3'h2: blink_half_ms = 9'h055;
            3'h3: blink_half_ms = 9'h0aa;
            3'h4: blink_half_ms = 9'h14f;
            default: blink_half_ms = 9'h02a;
        endcase
    endfunction

    // speed qualification; reserved codes never light
    function automatic logic speed_ok(input logic [2:0] q,
                                      input logic link,
                                      input logic spd100);
        case (q)
            `SPD_TEN: speed_ok = link && !spd100; // [RQ7]
            `SPD_HUNDRED: speed_ok = link && spd100; // [RQ7]
            default: speed_ok = 1'b0;
        endcase
    endfunction

    // source decode shared by all three outputs
    function automatic logic src_on(input logic [3:0] code,
                                    input logic [1:0] outn,
                                    input cond_type c,
                                    input logic spd);
        case (code)
            4'h0: src_on = c.coll;
            4'h1: src_on = c.err;
            4'h2: src_on = c.dup;
            4'h3: src_on = c.dup || (c.coll && c.blink);
            4'h4: src_on = spd;
            4'h5: src_on = c.link;
            4'h6: src_on = c.tx;
            4'h7: src_on = c.rx;
            4'h8: src_on = (outn != 2'd0) && (c.tx || c.rx); // [RQ3]
            4'h9: src_on = (outn != 2'd0) && c.link &&
                           !(c.rx && c.blink); // [RQ3]
            4'ha: src_on = c.link && !((c.tx || c.rx) && c.blink);
            4'hb: src_on = (c.tx || c.rx) && c.blink; // [RQ9]
            4'hc: src_on = c.tx && c.blink; // [RQ9]
            4'hd: src_on = c.rx && c.blink; // [RQ9]
            `SRC_IRQ_OR_COLB: begin
                if (outn == 2'd2) begin
                    src_on = c.irq; // [RQ1]
                end else if (outn == 2'd0) begin
                    src_on = c.coll && c.blink; // [RQ3]
                end else begin
                    src_on = 1'b0; // [RQ2]
                end
            end
            `SRC_OFF: src_on = 1'b0; // [RQ4]
            default: src_on = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, answer registered in the setup cycle

    // ready rises for the access phase that follows every setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= psel && !penable;
            if (psel && !penable) begin
                pslverr_r <= 1'b0;
                case (idx)
                    `IND_SRC_IDX: prdata_r <= {16'h0000, src_r};
                    `IND_TIM_IDX: prdata_r <= {16'h0000, tim_r};
                    `IND_POL_IDX: prdata_r <= {16'h0000, pol_r};
                    `IND_STAT_IDX: prdata_r <= {26'h0, pin_r, act_r};
                    default: begin
                        prdata_r <= 32'h0000_0000;
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // configuration registers; writes land at the end of the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_r <= `IND_SRC_RST;
            tim_r <= `IND_TIM_RST;
            pol_r <= `IND_POL_RST;
        end else if (wr_en) begin
            case (idx)
                `IND_SRC_IDX: src_r <= pwdata[15:0]; // [RQ1] [RQ2] [RQ3]
                `IND_TIM_IDX: tim_r <= pwdata[15:0] & `IND_TIM_WMASK;
                `IND_POL_IDX: pol_r <= pwdata[15:0] & `IND_POL_WMASK;
                default: ;
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////
    // millisecond enable from the core clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_r <= 16'h0000;
            ms_tick_r <= 1'b0;
        end else if (ms_cnt_r == 16'(MS_CYCLES - 1)) begin
            ms_cnt_r <= 16'h0000;
            ms_tick_r <= 1'b1;
        end else begin
            ms_cnt_r <= ms_cnt_r + 16'h0001;
            ms_tick_r <= 1'b0;
        end
    end

    // blink phase: toggles every half period, counted in ms ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_r <= 9'h000;
            blink_r <= 1'b0;
        end else if (ms_tick_r) begin
            if (blink_cnt_r >= blink_half_ms(blink_code) - 9'h001) begin
                blink_cnt_r <= 9'h000;
                blink_r <= !blink_r; // [RQ6]
            end else begin
                blink_cnt_r <= blink_cnt_r + 9'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse stretch: each event reloads its counter while present; the
    // timer granularity of 1 ms keeps the hold inside the doubling range
    assign ev = {line_st.collision, line_st.rx_error,
                 line_st.tx_active, line_st.rx_active};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                str_cnt_r[i] <= 12'h000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (ev[i]) begin
                    str_cnt_r[i] <= stretch_ms(stretch_code); // [RQ5]
                end else if (ms_tick_r && str_cnt_r[i] != 12'h000) begin
                    str_cnt_r[i] <= str_cnt_r[i] - 12'h001;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ev_str[i] = ev[i] ||
                        (stretch_code != 3'h0 &&
                         str_cnt_r[i] != 12'h000); // [RQ5]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source selection and pin drive
    always_comb begin
        cond.coll = ev_str[3];
        cond.err = ev_str[2];
        cond.tx = ev_str[1];
        cond.rx = ev_str[0];
        cond.dup = line_st.full_duplex;
        cond.link = line_st.link_up;
        cond.irq = line_st.irq;
        cond.blink = blink_r;
        act_nxt[2] = src_on(src_r[`SRC2_LSB +: 4], 2'd2, cond,
            speed_ok(tim_r[`SPD2_LSB +: 3], cond.link, line_st.speed_100));
        act_nxt[1] = src_on(src_r[`SRC1_LSB +: 4], 2'd1, cond,
            speed_ok(tim_r[`SPD1_LSB +: 3], cond.link, line_st.speed_100));
        act_nxt[0] = src_on(src_r[`SRC0_LSB +: 4], 2'd0, cond,
            speed_ok(tim_r[`SPD0_LSB +: 3], cond.link, line_st.speed_100));
    end

    // active level is low unless inverted; reset leaves the lamps dark
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_r <= 3'h0;
            pin_r <= 3'h7;
        end else begin
            act_r <= act_nxt;
            pin_r <= act_nxt ^ ~inv; // [RQ8]
        end
    end

    assign ind_pin = pin_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    a_apb_ready_timing: assert property (s_setup |=> s_access or !psel)
        else $error("apb ready not raised after setup");
    a_force_inactive: assert property ( // [RQ4]
        src_r[`SRC0_LSB +: 4] == `SRC_OFF |=> ind_pin[0] == !$past(inv[0]))
        else $error("forced off output zero lit");
    a_out_two_coll: assert property ( // [RQ1]
        src_r[`SRC2_LSB +: 4] == 4'h0 && line_st.collision
        |=> ind_pin[2] == $past(inv[2]))
        else $error("output two missed collision");
    a_out_one_noirq: assert property ( // [RQ2]
        src_r[`SRC1_LSB +: 4] == `SRC_IRQ_OR_COLB
        |=> ind_pin[1] == !$past(inv[1]))
        else $error("output one lit on code 1110");
    a_out_zero_noact: assert property ( // [RQ3]
        src_r[`SRC0_LSB +: 4] == 4'h8 |=> act_r[0] == 1'b0)
        else $error("output zero lit on activity code");
    a_stretch_hold: assert property ( // [RQ5]
        stretch_code != 3'h0 && line_st.tx_active |=> ev_str[1] [*8])
        else $error("transmit event not stretched");
    a_blink_on_tick: assert property ( // [RQ6]
        $changed(blink_r) |-> $past(ms_tick_r))
        else $error("blink phase moved off the ms enable");
    a_speed_hundred: assert property ( // [RQ7]
        src_r[`SRC2_LSB +: 4] == 4'h4 &&
        tim_r[`SPD2_LSB +: 3] == `SPD_HUNDRED &&
        line_st.link_up && line_st.speed_100
        |=> ind_pin[2] == $past(inv[2]))
        else $error("speed qualified output two dark");
    a_pin_polarity: assert property ( // [RQ8]
        $past(inv) == 3'h0 |-> ind_pin == ~act_r)
        else $error("default polarity not active low");
    a_blink_idle_off: assert property ( // [RQ9]
        src_r[`SRC2_LSB +: 4] == 4'hb && !ev_str[1] && !ev_str[0]
        |=> act_r[2] == 1'b0)
        else $error("blink source lit without activity");

endmodule
`default_nettype wire

// file: testbench/ind_lamps.sv
// lamp model standing on the three indicator pins
// assumes the bench tells it how each lamp is wired (sink or source)
`timescale 1ns/1ps
`default_nettype none
module ind_lamps (
    // pins from the block
    input wire logic [2:0] ind_pin,
    // wiring: 1 means lamp lights on a high pin
    input wire logic [2:0] invert,
    // lamp states seen by the bench
    output logic [2:0] lit
);
    // a sinking lamp lights on a low pin, a sourcing one on a high pin
    assign lit = (invert & ind_pin) | (~invert & ~ind_pin);
endmodule
`default_nettype wire

// file: testbench/ind_ctrl_bench.sv
// self-checking bench for the indicator block
// assumes the package, the constants header and the lamp model
`timescale 1ns/1ps
`default_nettype none
module ind_ctrl_bench;
    import ind_ctrl_pkg::*;
    typedef struct packed {
        logic [15:0] src;
        logic [7:0] ln;
        logic [2:0] pins;
    } row_type;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    line_state_type line_st = '0;
    logic [2:0] ind_pin;
    logic [2:0] inv = 3'b000;
    logic [2:0] lit;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic er;
    int cnt;
    // source word, line conditions, expected pins (active low)
    row_type rows [13] = '{
        '{16'h0000, 8'h10, 3'b000}, '{16'h0111, 8'h08, 3'b000},
        '{16'h0222, 8'h20, 3'b000}, '{16'h0333, 8'h20, 3'b000},
        '{16'h0555, 8'h80, 3'b000}, '{16'h0666, 8'h04, 3'b000},
        '{16'h0777, 8'h02, 3'b000}, '{16'h0444, 8'h80, 3'b001},
        '{16'h0444, 8'hc0, 3'b110}, '{16'h0eef, 8'h01, 3'b011},
        '{16'h09a9, 8'h80, 3'b001}, '{16'h08f8, 8'h04, 3'b011},
        '{16'h0fff, 8'hff, 3'b111}};

    ////////////////////////////////////////////////////////////////////
    // block and lamps; 4 cycles per ms keeps the long times short
    ind_ctrl #(.MS_CYCLES(4)) ind_ctrl_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_st(line_st), .ind_pin(ind_pin));
    ind_lamps ind_lamps_inst (.ind_pin(ind_pin), .invert(inv), .lit(lit));

    ////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        forever #12.5 pclk = ~pclk;
    end

    // compare one value and count it
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer; waits for pready, never assumes its latency
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [15:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            failures++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // cycles until pin two changes; a hang ends the run
    task automatic wait_edge(input int lim);
        logic v;
        v = ind_pin[2];
        cnt = 0;
        do begin
            @(posedge pclk);
            cnt++;
        end while (ind_pin[2] === v && cnt < lim);
        if (ind_pin[2] === v) begin
            failures++;
            final_report();
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        chk("pins in reset", ind_pin, 3'b111);
        presetn <= 1'b1;
        apb(1'b0, 12'h058, 16'h0);
        chk("source reset", rd, 32'h4a44);
        apb(1'b0, 12'h060, 16'h0);
        chk("timing reset", rd, 32'h4205);
        apb(1'b0, 12'h064, 16'h0);
        chk("polarity reset", rd, 32'h0);
        apb(1'b0, 12'h070, 16'h0);
        chk("unmapped error", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, 12'h060, 16'hffff);
        apb(1'b0, 12'h060, 16'h0);
        chk("timing top bit", rd, 32'h7fff);
        $display("test registers done");
        // no stretch, 10M on outputs two and one, 100M on zero
        apb(1'b1, 12'h060, 16'h0005);
        foreach (rows[k]) begin
            line_st <= '0;
            apb(1'b1, 12'h058, rows[k].src);
            line_st <= rows[k].ln;
            cyc(3);
            chk("rows", ind_pin, rows[k].pins);
        end
        $display("test table done");
        // output two qualified for 100 mbit, outputs one and zero for 10 mbit
        apb(1'b1, 12'h060, 16'h0140);
        apb(1'b1, 12'h058, 16'h0444);
        line_st <= 8'hc0;
        cyc(3);
        chk("speed pins", ind_pin, 3'b011);
        apb(1'b0, 12'h068, 16'h0);
        chk("status word", rd, 32'h1c);
        $display("test speed done");
        // one-cycle transmit pulse stretched by code 001
        line_st <= '0;
        apb(1'b1, 12'h060, 16'h1005);
        apb(1'b1, 12'h058, 16'h0666);
        cyc(5);
        line_st <= 8'h04;
        @(posedge pclk);
        line_st <= '0;
        wait_edge(20);
        wait_edge(200);
        chk("stretch span", cnt >= 84 && cnt <= 90, 1'b1);
        $display("test stretch done");
        // blinking activity at the fastest rate, half period 21 ms
        apb(1'b1, 12'h060, 16'h0005);
        // out two blinks activity, out one transmit, out zero receive;
        // the first edge may be the lamp coming on, so skip two edges
        apb(1'b1, 12'h058, 16'h0bcd);
        line_st <= 8'h04;
        wait_edge(200);
        wait_edge(200);
        wait_edge(200);
        chk("blink half period", cnt >= 83 && cnt <= 85, 1'b1);
        chk("blink pins", ind_pin, {ind_pin[2], ind_pin[2], 1'b1});
        line_st <= '0;
        cyc(3);
        chk("blink idle", ind_pin, 3'b111);
        $display("test blink done");
        // inverted outputs with sourcing lamps; forced off stays dark
        apb(1'b1, 12'h064, 16'h7000);
        inv <= 3'b111;
        apb(1'b1, 12'h058, 16'h0fff);
        cyc(3);
        chk("inverted pins", ind_pin, 3'b000);
        chk("lamps dark", lit, 3'b000);
        $display("test polarity done");
        // reset in mid run: pins high and inversion back to default
        presetn <= 1'b0;
        cyc(2);
        chk("pins mid reset", ind_pin, 3'b111);
        presetn <= 1'b1;
        inv <= 3'b000;
        apb(1'b0, 12'h064, 16'h0);
        chk("polarity after reset", rd, 32'h0);
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
